/* File: rtl/spc_consts.svh */
// constants for the system interface parity checker
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH
`define SPC_DATA_W 64
`define SPC_LANES 8
`define SPC_LANE_W 8
`define SPC_WORDS 2
`define SPC_LANES_PER_WORD 4
`define SPC_CMD_W 9
`define SPC_CMD_NOCHECK 4
`define SPC_CMD_BAD_DATA 5
`define SPC_CMD_NOT_RESP 6
`define SPC_CMD_LAST 7
`endif

/* File: rtl/spc_pkg.sv */
// types for the system interface parity checker
package spc_pkg;
	typedef enum logic [1:0] {
		SPC_RX_SINGLE,
		SPC_RX_BLOCK_DATA,
		SPC_RX_BLOCK_INSTR,
		SPC_RX_EXT_WRITE
	} spc_rx_kind_t;
endpackage : spc_pkg

/* File: rtl/spc_lane_parity.sv */
// per byte lane even parity of a doubleword
`timescale 1ns/10ps
`default_nettype none
`include "spc_consts.svh"
module spc_lane_parity (
	input wire logic [`SPC_DATA_W-1:0] data,
	output logic [`SPC_LANES-1:0] lanePar
);
	genvar i;
	generate
		for (i = 0; i < `SPC_LANES; i = i + 1) begin : gLane
			assign lanePar[i] = ^data[i*`SPC_LANE_W +: `SPC_LANE_W];
		end
	endgenerate
endmodule : spc_lane_parity
`default_nettype wire

/* File: rtl/spc_parity_checker.sv */
// system interface parity generation and checking
// Contract
// - even parity on cache to interface data
// - generate check bits for outgoing data
// - forward cache check bits unchanged outward
// - never check external write data
// - no-check flag suppresses read response check
// - no-check flag is command bit four
// - no-check refill writes generated parity
// - instruction refill checks first doubleword only
// - that doubleword checked per byte lane
// - single reads evaluated over all 64 bits
// - word parity is XOR of four bytes
// - addresses neither checked nor given check bits
// - mismatch raises cache error, no correction
// - command check bit driven zero, never read
// - primary error item from cache sent marked erroneous
`timescale 1ns/10ps
`default_nettype none
`include "spc_consts.svh"
module spc_parity_checker (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic txValid,
	input wire logic txIsAddr,
	input wire logic txFromCache,
	input wire logic txPrimaryErr,
	input wire logic [`SPC_DATA_W-1:0] txData,
	input wire logic [`SPC_LANES-1:0] txCacheCheck,
	input wire logic rxValid,
	input wire logic rxIsAddr,
	input wire logic rxFirst,
	input wire spc_pkg::spc_rx_kind_t rxKind,
	input wire logic [`SPC_DATA_W-1:0] rxData,
	input wire logic [`SPC_LANES-1:0] rxCheck,
	input wire logic [`SPC_CMD_W-1:0] systemCommandBus,
	output logic outValid,
	output logic [`SPC_DATA_W-1:0] outData,
	output logic [`SPC_LANES-1:0] outCheck,
	output logic outBadData,
	output logic commandCheckBit,
	output logic cacheWrValid,
	output logic [`SPC_DATA_W-1:0] cacheWrData,
	output logic [`SPC_WORDS-1:0] cacheWrPar,
	output logic [`SPC_LANES-1:0] rxBadLanes,
	output logic cacheErrExc
);
	logic [`SPC_LANES-1:0] txGenPar;
	logic [`SPC_LANES-1:0] rxGenPar;
	logic [`SPC_LANES-1:0] rxLaneBad;
	logic [`SPC_WORDS-1:0] rxWordGen;
	logic [`SPC_WORDS-1:0] rxWordSup;
	logic noCheckFlag;
	logic isResponse;
	logic isRefill;
	logic checkOn;
	logic errDetect;
	logic outValid_reg;
	logic [`SPC_DATA_W-1:0] outData_reg;
	logic [`SPC_LANES-1:0] outCheck_reg;
	logic outBadData_reg;
	logic commandCheckBit_reg;
	logic cacheWrValid_reg;
	logic [`SPC_DATA_W-1:0] cacheWrData_reg;
	logic [`SPC_WORDS-1:0] cacheWrPar_reg;
	logic [`SPC_LANES-1:0] rxBadLanes_reg;
	logic cacheErrExc_reg;

	spc_lane_parity uTxPar (
		.data(txData),
		.lanePar(txGenPar)
	);
	spc_lane_parity uRxPar (
		.data(rxData),
		.lanePar(rxGenPar)
	);

	assign noCheckFlag = systemCommandBus[`SPC_CMD_NOCHECK];
	assign isResponse = ~systemCommandBus[`SPC_CMD_NOT_RESP];
	// lane bad when the ones count of its data byte plus check bit is odd
	assign rxLaneBad = rxGenPar ^ rxCheck;

	genvar w;
	generate
		for (w = 0; w < `SPC_WORDS; w = w + 1) begin : gWord
			assign rxWordGen[w] = ^rxGenPar[w*`SPC_LANES_PER_WORD +: `SPC_LANES_PER_WORD];
			assign rxWordSup[w] = ^rxCheck[w*`SPC_LANES_PER_WORD +: `SPC_LANES_PER_WORD];
		end
	endgenerate

	assign isRefill = rxValid & ~rxIsAddr & isResponse
		& ((rxKind == spc_pkg::SPC_RX_BLOCK_DATA) | (rxKind == spc_pkg::SPC_RX_BLOCK_INSTR));

	assign checkOn = rxValid & ~rxIsAddr & isResponse & ~noCheckFlag
		& (rxKind != spc_pkg::SPC_RX_EXT_WRITE)
		& ((rxKind != spc_pkg::SPC_RX_BLOCK_INSTR) | rxFirst);
	assign errDetect = checkOn & (|rxLaneBad);

	// outgoing item, one cycle of latency
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			outValid_reg <= 1'b0;
			outData_reg <= 64'h0000000000000000;
			outCheck_reg <= 8'h00;
			outBadData_reg <= 1'b0;
		end else begin
			outValid_reg <= txValid;
			if (txValid) begin
				outData_reg <= txData;
				if (txIsAddr) begin
					outCheck_reg <= 8'h00;
				end else if (txFromCache) begin
					outCheck_reg <= txCacheCheck;
				end else begin
					outCheck_reg <= txGenPar;
				end
				outBadData_reg <= ~txIsAddr & txFromCache & txPrimaryErr;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			commandCheckBit_reg <= 1'b0;
		end else begin
			commandCheckBit_reg <= 1'b0;
		end
	end

	// refill write into the cache
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			cacheWrValid_reg <= 1'b0;
			cacheWrData_reg <= 64'h0000000000000000;
			cacheWrPar_reg <= 2'h0;
		end else begin
			cacheWrValid_reg <= isRefill;
			if (isRefill) begin
				cacheWrData_reg <= rxData;
				if (noCheckFlag) begin
					cacheWrPar_reg <= rxWordGen;
				end else begin
					cacheWrPar_reg <= rxWordSup;
				end
			end
		end
	end

	// lane status always spans the whole bus, narrow sizes included
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			rxBadLanes_reg <= 8'h00;
		end else begin
			if (rxValid && !rxIsAddr) begin
				rxBadLanes_reg <= rxLaneBad;
			end else begin
				rxBadLanes_reg <= 8'h00;
			end
		end
	end

	// no corrector: software handles the trap
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			cacheErrExc_reg <= 1'b0;
		end else begin
			cacheErrExc_reg <= errDetect;
		end
	end

	assign outValid = outValid_reg;
	assign outData = outData_reg;
	assign outCheck = outCheck_reg;
	assign outBadData = outBadData_reg;
	assign commandCheckBit = commandCheckBit_reg;
	assign cacheWrValid = cacheWrValid_reg;
	assign cacheWrData = cacheWrData_reg;
	assign cacheWrPar = cacheWrPar_reg;
	assign rxBadLanes = rxBadLanes_reg;
	assign cacheErrExc = cacheErrExc_reg;

	sequence sTxGen;
		txValid && !txIsAddr && !txFromCache;
	endsequence
	sequence sBadRead;
		rxValid && !rxIsAddr && isResponse && !noCheckFlag
			&& rxKind == spc_pkg::SPC_RX_SINGLE && (rxGenPar != rxCheck);
	endsequence

	AST_TX_EVEN: assert property (@(posedge sys_clk) disable iff (!resetn)
		sTxGen |=> (^{outData, outCheck} == 1'b0))
		else $error("outgoing data and check bits not even");
	AST_TX_GEN: assert property (@(posedge sys_clk) disable iff (!resetn)
		sTxGen |=> outValid && (outCheck == $past(txGenPar)))
		else $error("generated check bits wrong");
	AST_TX_PASS: assert property (@(posedge sys_clk) disable iff (!resetn)
		txValid && !txIsAddr && txFromCache |=> outCheck == $past(txCacheCheck))
		else $error("cache check bits altered");
	AST_EXTWR_NOCHK: assert property (@(posedge sys_clk) disable iff (!resetn)
		rxKind == spc_pkg::SPC_RX_EXT_WRITE |=> !cacheErrExc)
		else $error("external write data was checked");
	AST_NOCHECK: assert property (@(posedge sys_clk) disable iff (!resetn)
		systemCommandBus[`SPC_CMD_NOCHECK] |=> !cacheErrExc)
		else $error("no-check element raised an error");
	AST_BAD_READ: assert property (@(posedge sys_clk) disable iff (!resetn)
		sBadRead |=> cacheErrExc ##1 !cacheErrExc || $past(errDetect))
		else $error("checked single read error missed");
	AST_NC_REFILL: assert property (@(posedge sys_clk) disable iff (!resetn)
		isRefill && noCheckFlag |=> cacheWrValid
			&& ^{cacheWrData[31:0], cacheWrPar[0]} == 1'b0
			&& ^{cacheWrData[63:32], cacheWrPar[1]} == 1'b0)
		else $error("unchecked refill word parity not even");
	AST_IFETCH_LATER: assert property (@(posedge sys_clk) disable iff (!resetn)
		rxKind == spc_pkg::SPC_RX_BLOCK_INSTR && !rxFirst |=> !cacheErrExc)
		else $error("later instruction doubleword was checked");
	AST_WORD_FOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
		isRefill && !noCheckFlag |=> cacheWrPar == {^$past(rxCheck[7:4]), ^$past(rxCheck[3:0])})
		else $error("word parity not folded from byte bits");
	AST_ADDR_CHK: assert property (@(posedge sys_clk) disable iff (!resetn)
		txValid && txIsAddr |=> outCheck == 8'h00 && !outBadData)
		else $error("address carried check bits");
	AST_CMD_ZERO: assert property (@(posedge sys_clk) disable iff (!resetn)
		outValid |-> !commandCheckBit)
		else $error("command check bit not zero");
	AST_PRIM_ERR: assert property (@(posedge sys_clk) disable iff (!resetn)
		txValid && !txIsAddr && txFromCache && txPrimaryErr |=> outValid && outBadData)
		else $error("primary error item not marked");
endmodule : spc_parity_checker
`default_nettype wire

/* File: verif/spc_agent_model.sv */
// external agent model driving read response data
`timescale 1ns/10ps
`default_nettype none
`include "spc_consts.svh"
module spc_agent_model (
	input wire logic [`SPC_DATA_W-1:0] lineData,
	input wire logic [`SPC_LANES-1:0] corruptMask,
	input wire logic noCheck,
	input wire logic notResp,
	output logic [`SPC_DATA_W-1:0] rxData,
	output logic [`SPC_LANES-1:0] rxCheck,
	output logic [`SPC_CMD_W-1:0] systemCommandBus
);
	always_comb begin
		rxData = lineData;
		// good, not-last element: check and response flags vary
		systemCommandBus = '0;
		systemCommandBus[`SPC_CMD_NOT_RESP] = notResp;
		systemCommandBus[`SPC_CMD_NOCHECK] = noCheck;
		for (int i = 0; i < `SPC_LANES; i++) begin
			rxCheck[i] = ^lineData[i*`SPC_LANE_W +: `SPC_LANE_W] ^ corruptMask[i];
		end
	end
endmodule : spc_agent_model
`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench for the parity checker
`timescale 1ns/10ps
`default_nettype none
`include "spc_consts.svh"
module tb;
	logic sys_clk = 1'h0;
	logic resetn = 1'h0;
	logic txValid = 1'h0, txIsAddr = 1'h0, txFromCache = 1'h0, txPrimaryErr = 1'h0;
	logic rxValid = 1'h0, rxIsAddr = 1'h0, rxFirst = 1'h0, noCheck = 1'h0, notResp = 1'h0;
	logic [63:0] txData = '0, lineData = '0, rxData, outData, cacheWrData;
	logic [7:0] txCacheCheck = '0, corruptMask = '0, rxCheck, outCheck, rxBadLanes;
	spc_pkg::spc_rx_kind_t rxKind = spc_pkg::SPC_RX_SINGLE;
	logic [8:0] systemCommandBus;
	logic outValid, outBadData, commandCheckBit, cacheWrValid, cacheErrExc;
	logic [1:0] cacheWrPar;
	int err_total = 0, samples_checked = 0;
	logic [31:0] rnd = 32'h0000001C;
	always #2 sys_clk = ~sys_clk;
	spc_parity_checker dut_u (.sys_clk(sys_clk), .resetn(resetn), .txValid(txValid),
		.txIsAddr(txIsAddr), .txFromCache(txFromCache), .txPrimaryErr(txPrimaryErr),
		.txData(txData), .txCacheCheck(txCacheCheck), .rxValid(rxValid), .rxIsAddr(rxIsAddr),
		.rxFirst(rxFirst), .rxKind(rxKind), .rxData(rxData), .rxCheck(rxCheck),
		.systemCommandBus(systemCommandBus), .outValid(outValid), .outData(outData),
		.outCheck(outCheck), .outBadData(outBadData), .commandCheckBit(commandCheckBit),
		.cacheWrValid(cacheWrValid), .cacheWrData(cacheWrData), .cacheWrPar(cacheWrPar),
		.rxBadLanes(rxBadLanes), .cacheErrExc(cacheErrExc));
	spc_agent_model agent_u (.lineData(lineData), .corruptMask(corruptMask),
		.noCheck(noCheck), .notResp(notResp), .rxData(rxData), .rxCheck(rxCheck),
		.systemCommandBus(systemCommandBus));
	function automatic logic [7:0] lanes(input logic [63:0] d);
		for (int i = 0; i < 8; i++) lanes[i] = ^d[8*i +: 8];
	endfunction : lanes
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			$display("Error %s expected %h seen %h", name, exp, seen);
			err_total++;
		end
	endtask : chk
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : results
	task automatic txStep(input logic fromCache, input logic perr);
		rnd = xs(rnd);
		txData[31:0] = rnd;
		rnd = xs(rnd);
		txData[63:32] = rnd;
		txCacheCheck = rnd[7:0];
		txFromCache = fromCache;
		txPrimaryErr = perr;
		txValid = 1'h1;
		@(negedge sys_clk);
		chk("outValid", outValid, 1'h1);
		chk("outData", outData, txData);
		chk("outCheck", outCheck, txIsAddr ? 8'h00
			: fromCache ? txCacheCheck : lanes(txData));
		chk("outBadData", outBadData, !txIsAddr & fromCache & perr);
		chk("commandCheckBit", commandCheckBit, 1'h0);
	endtask : txStep
	task automatic rxStep(input spc_pkg::spc_rx_kind_t k, input logic f, input logic nc,
		input logic [7:0] m, input logic a);
		logic refill, exc;
		rnd = xs(rnd);
		lineData = {rnd, xs(rnd)};
		rxKind = k;
		{rxFirst, noCheck, corruptMask, rxIsAddr, rxValid} = {f, nc, m, a, 1'h1};
		refill = !a && !notResp
			&& (k == spc_pkg::SPC_RX_BLOCK_DATA || k == spc_pkg::SPC_RX_BLOCK_INSTR);
		exc = !a && !notResp && !nc && k != spc_pkg::SPC_RX_EXT_WRITE && m != 8'h00
			&& (k != spc_pkg::SPC_RX_BLOCK_INSTR || f);
		@(negedge sys_clk);
		chk("cacheWrValid", cacheWrValid, refill);
		if (refill) begin
			chk("cacheWrData", cacheWrData, lineData);
			chk("cacheWrPar", cacheWrPar, nc ? {^lineData[63:32], ^lineData[31:0]}
				: {^rxCheck[7:4], ^rxCheck[3:0]});
		end
		chk("rxBadLanes", rxBadLanes, a ? 8'h00 : m);
		chk("cacheErrExc", cacheErrExc, exc);
	endtask : rxStep
	initial begin
		// generous bound: the run needs about a hundred cycles
		#20000;
		err_total++;
		results();
	end
	initial begin
		repeat (8) @(negedge sys_clk);
		resetn = 1'h1;
		chk("resetCacheErrExc", cacheErrExc, 1'h0);
		// corner cases first, then random mix back to back
		txStep(1'h0, 1'h1);
		txStep(1'h1, 1'h1);
		txStep(1'h1, 1'h0);
		// address item: no check bits, never marked
		txIsAddr = 1'h1;
		txStep(1'h1, 1'h1);
		txIsAddr = 1'h0;
		for (int n = 0; n < 16; n++) txStep(rnd[0], rnd[1]);
		$display("test transmit done");
		rxStep(spc_pkg::SPC_RX_BLOCK_INSTR, 1'h0, 1'h0, 8'h80, 1'h0);
		rxStep(spc_pkg::SPC_RX_SINGLE, 1'h0, 1'h0, 8'hFF, 1'h1);
		// non-response data: no refill, no trap
		notResp = 1'h1;
		rxStep(spc_pkg::SPC_RX_BLOCK_DATA, 1'h1, 1'h0, 8'h10, 1'h0);
		notResp = 1'h0;
		for (int n = 0; n < 64; n++) begin
			rxStep(spc_pkg::spc_rx_kind_t'(n[1:0]), n[2], n[3], n[4] ? rnd[15:8] : 8'h01, 1'h0);
		end
		$display("test receive done");
		txValid = 1'h0;
		rxValid = 1'h0;
		@(negedge sys_clk);
		chk("idleCacheErrExc", cacheErrExc, 1'h0);
		chk("idleOutValid", outValid, 1'h0);
		chk("idleCacheWrValid", cacheWrValid, 1'h0);
		chk("idleRxBadLanes", rxBadLanes, 8'h00);
		// mid-run reset with traffic still offered
		txValid = 1'h1;
		rxValid = 1'h1;
		resetn = 1'h0;
		repeat (2) @(negedge sys_clk);
		chk("rstFlags", {outValid, outBadData, commandCheckBit, cacheWrValid, cacheErrExc,
			cacheWrPar, rxBadLanes, outCheck}, 64'h0000000000000000);
		chk("rstOutData", outData, 64'h0000000000000000);
		chk("rstCacheWrData", cacheWrData, 64'h0000000000000000);
		rxValid = 1'h0;
		resetn = 1'h1;
		// first request right at the first edge after release
		txStep(1'h0, 1'h0);
		results();
	end
endmodule : tb
`default_nettype wire
